/* src/atc_pkg.sv */
package atc_pkg;
    // Module address matched against the first frame byte.
    localparam logic [7:0] MOD_ADDR = 8'h01;
    // Instruction codes.
    localparam logic [7:0] I_ACCU_COORD = 8'h27;
    localparam logic [7:0] I_XREG_OP = 8'h21;
    localparam logic [7:0] I_ACCU_AXIS = 8'h22;
    localparam logic [7:0] I_ACCU_GLOBAL = 8'h23;
    // Calculation type codes.
    localparam logic [7:0] CX_ADD = 8'h00;
    localparam logic [7:0] CX_SUB = 8'h01;
    localparam logic [7:0] CX_MUL = 8'h02;
    localparam logic [7:0] CX_DIV = 8'h03;
    localparam logic [7:0] CX_MOD = 8'h04;
    localparam logic [7:0] CX_AND = 8'h05;
    localparam logic [7:0] CX_OR = 8'h06;
    localparam logic [7:0] CX_XOR = 8'h07;
    localparam logic [7:0] CX_NOT = 8'h08;
    localparam logic [7:0] CX_LOAD = 8'h09;
    localparam logic [7:0] CX_SWAP = 8'h0A;
    // Persistence global parameter and banks.
    localparam logic [7:0] GP_PERSIST = 8'h54;
    localparam logic [7:0] BANK_0 = 8'h00;
    localparam logic [7:0] BANK_2 = 8'h02;
    localparam logic [7:0] BANK_3 = 8'h03;
    localparam logic [7:0] COORD_MAX = 8'h14;
    localparam int N_COORD = 21;
    localparam logic [7:0] MOTOR_0 = 8'h00;
    // Reply status codes.
    localparam logic [7:0] ST_OK = 8'h64;
    localparam logic [7:0] ST_BAD_CSUM = 8'h01;
    localparam logic [7:0] ST_BAD_CMD = 8'h02;
    localparam logic [7:0] ST_BAD_TYPE = 8'h03;
    localparam logic [7:0] ST_BAD_VAL = 8'h04;
    // Frame byte indices.
    localparam logic [3:0] FB_ADDR = 4'h0;
    localparam logic [3:0] FB_INSTR = 4'h1;
    localparam logic [3:0] FB_TYPE = 4'h2;
    localparam logic [3:0] FB_BANK = 4'h3;
    localparam logic [3:0] FB_CSUM = 4'h8;
    localparam logic ACC_RST = 1'b0;
    typedef enum logic [2:0] {
        S_RECV = 3'b001,
        S_EXEC = 3'b010,
        S_RPLY = 3'b100
    } atc_state_type;
endpackage : atc_pkg

/* src/atc_immediate_cmd_a.sv */
`timescale 1ns/1ns
// Function
// - Code 39 stores the accumulator in the chosen coordinate slot; value ignored.
// - Setting 84 selects volatile-only or also non-volatile slots; default volatile.
// - Slot zero is never written to non-volatile storage.
// - Code 33 combines accumulator and X by type, result into the accumulator for types 0..7.
// - Types 0..4 add, subtract, multiply, divide and modulo by X.
// - Types 5..7 AND, OR, XOR with X; type 8 inverts X.
// - Type 9 copies the accumulator into X, accumulator unchanged.
// - Type 10 swaps accumulator and X at once.
// - Code 34 writes the accumulator to the numbered axis parameter.
// - Code 35 writes the accumulator to a global parameter in bank 0, 2 or 3.
module atc_immediate_cmd_a (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_data_i,
    output logic byte_ready_o,
    input wire logic prog_valid_i,
    input wire logic [7:0] prog_instr_i,
    input wire logic [7:0] prog_type_i,
    input wire logic [7:0] prog_bank_i,
    output logic prog_ready_o,
    output logic prog_done_o,
    input wire logic acc_load_i,
    input wire logic [31:0] acc_load_val_i,
    input wire logic nv_restore_i,
    input wire logic [4:0] nv_slot_i,
    input wire logic [31:0] nv_data_i,
    input wire logic [4:0] coord_sel_i,
    output logic [31:0] coord_o,
    output logic reply_valid_o,
    output logic [7:0] reply_status_o,
    output logic [31:0] reply_value_o,
    output logic ap_we_o,
    output logic [7:0] ap_num_o,
    output logic [7:0] ap_motor_o,
    output logic [31:0] ap_data_o,
    output logic gp_we_o,
    output logic [7:0] gp_num_o,
    output logic [7:0] gp_bank_o,
    output logic [31:0] gp_data_o,
    output logic nv_we_o,
    output logic [4:0] nv_slot_o,
    output logic [31:0] nv_data_o,
    output logic [31:0] acc_o,
    output logic [31:0] xreg_o,
    output logic persist_o
);
    import atc_pkg::*;

    atc_state_type st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sum_q, addr_q, ci_q, ct_q, cb_q, status_c;
    logic dir_q, bad_csum_q, persist_q, ok_c, ex, byte_take, prog_take, fend;
    logic [31:0] crd_q [0:N_COORD-1];

    // Returns {new X, new accumulator}; unused codes leave both unchanged.
    function automatic logic [63:0] x_arith(input logic [7:0] t, input logic signed [31:0] a,
                                          input logic signed [31:0] x);
        logic signed [31:0] r;
        r = a;
        case (t)
            CX_ADD: r = a + x;
            CX_SUB: r = a - x;
            CX_MUL: r = a * x;
            CX_DIV: r = a / x;
            CX_MOD: r = a % x;
            CX_AND: r = a & x;
            CX_OR: r = a | x;
            CX_XOR: r = a ^ x;
            default: r = a;
        endcase
        if (t == CX_NOT) return {~x, a};
        if (t == CX_LOAD) return {a, a};
        if (t == CX_SWAP) return {a, x};
        return {x, r};
    endfunction : x_arith

    function automatic logic slot_ok(input logic [7:0] s);
        return s <= COORD_MAX;
    endfunction : slot_ok

    assign byte_take = byte_valid_i && byte_ready_o;
    assign prog_take = prog_valid_i && prog_ready_o && !byte_valid_i;
    assign fend = byte_take && cnt_q == FB_CSUM;
    assign ex = st_q == S_EXEC && ok_c;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        case (st_q)
            S_RECV: begin
                if (byte_take) begin
                    cnt_d = (cnt_q == FB_CSUM) ? 4'h0 : cnt_q + 4'h1;
                end
                if ((fend && addr_q == MOD_ADDR) || prog_take) begin
                    st_d = S_EXEC;
                end
            end
            S_EXEC: st_d = S_RPLY;
            default: st_d = S_RECV;
        endcase
    end

    always_comb begin
        status_c = ST_OK;
        if (bad_csum_q) begin
            status_c = ST_BAD_CSUM;
        end else if (ci_q == I_ACCU_COORD) begin
            if (!slot_ok(ct_q)) status_c = ST_BAD_TYPE;
            else if (cb_q != MOTOR_0) status_c = ST_BAD_VAL;
        end else if (ci_q == I_XREG_OP) begin
            if (ct_q > CX_SWAP) status_c = ST_BAD_TYPE;
            else if ((ct_q == CX_DIV || ct_q == CX_MOD) && xreg_o == 32'h0) begin
                status_c = ST_BAD_VAL;
            end
        end else if (ci_q == I_ACCU_AXIS) begin
            if (cb_q != MOTOR_0) status_c = ST_BAD_VAL;
        end else if (ci_q == I_ACCU_GLOBAL) begin
            if (cb_q != BANK_0 && cb_q != BANK_2 && cb_q != BANK_3) begin
                status_c = ST_BAD_VAL;
            end
        end else begin
            status_c = ST_BAD_CMD;
        end
        ok_c = status_c == ST_OK;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            st_q <= S_RECV;
            cnt_q <= 4'h0;
            byte_ready_o <= 1'b0;
            prog_ready_o <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            byte_ready_o <= st_d == S_RECV;
            prog_ready_o <= st_d == S_RECV && cnt_d == 4'h0;
        end
    end

    // Frame capture; the value bytes only enter the running sum.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            sum_q <= 8'h00;
            addr_q <= 8'h00;
            ci_q <= 8'h00;
            ct_q <= 8'h00;
            cb_q <= 8'h00;
            dir_q <= 1'b0;
            bad_csum_q <= 1'b0;
        end else if (prog_take) begin
            ci_q <= prog_instr_i;
            ct_q <= prog_type_i;
            cb_q <= prog_bank_i;
            dir_q <= 1'b0;
            bad_csum_q <= 1'b0;
        end else if (byte_take) begin
            sum_q <= fend ? 8'h00 : sum_q + byte_data_i;
            if (cnt_q == FB_ADDR) addr_q <= byte_data_i;
            if (cnt_q == FB_INSTR) ci_q <= byte_data_i;
            if (cnt_q == FB_TYPE) ct_q <= byte_data_i;
            if (cnt_q == FB_BANK) cb_q <= byte_data_i;
            if (fend) begin
                dir_q <= 1'b1;
                bad_csum_q <= sum_q != byte_data_i;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            acc_o <= {32{ACC_RST}};
            xreg_o <= {32{ACC_RST}};
        end else if (ex && ci_q == I_XREG_OP) begin
            {xreg_o, acc_o} <= x_arith(ct_q, acc_o, xreg_o);
        end else if (acc_load_i && st_q != S_EXEC) begin
            acc_o <= acc_load_val_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            persist_q <= 1'b0;
        end else if (ex && ci_q == I_ACCU_GLOBAL && ct_q == GP_PERSIST && cb_q == BANK_0) begin
            persist_q <= acc_o != 32'h0;
        end
    end
    assign persist_o = persist_q;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < N_COORD; i++) crd_q[i] <= 32'h0;
        end else if (ex && ci_q == I_ACCU_COORD) begin
            crd_q[ct_q[4:0]] <= acc_o;
        end else if (nv_restore_i && persist_q && nv_slot_i != 5'h00
                     && slot_ok({3'h0, nv_slot_i})) begin
            crd_q[nv_slot_i] <= nv_data_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            coord_o <= 32'h0;
        end else begin
            coord_o <= slot_ok({3'h0, coord_sel_i}) ? crd_q[coord_sel_i] : 32'h0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            nv_we_o <= 1'b0;
            nv_slot_o <= 5'h00;
            nv_data_o <= 32'h0;
        end else begin
            nv_we_o <= ex && ci_q == I_ACCU_COORD && persist_q && ct_q != 8'h00;
            nv_slot_o <= ct_q[4:0];
            nv_data_o <= acc_o;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            ap_we_o <= 1'b0;
            gp_we_o <= 1'b0;
            ap_num_o <= 8'h00;
            ap_motor_o <= 8'h00;
            ap_data_o <= 32'h0;
            gp_num_o <= 8'h00;
            gp_bank_o <= 8'h00;
            gp_data_o <= 32'h0;
        end else begin
            ap_we_o <= ex && ci_q == I_ACCU_AXIS;
            gp_we_o <= ex && ci_q == I_ACCU_GLOBAL;
            ap_num_o <= ct_q;
            ap_motor_o <= cb_q;
            ap_data_o <= acc_o;
            gp_num_o <= ct_q;
            gp_bank_o <= cb_q;
            gp_data_o <= acc_o;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            reply_valid_o <= 1'b0;
            prog_done_o <= 1'b0;
            reply_status_o <= 8'h00;
            reply_value_o <= 32'h0;
        end else begin
            reply_valid_o <= st_q == S_EXEC && dir_q;
            prog_done_o <= st_q == S_EXEC && !dir_q;
            if (st_q == S_EXEC) reply_status_o <= status_c;
            reply_value_o <= 32'h0;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_run(logic [7:0] code);
        st_q == S_EXEC && ok_c && ci_q == code;
    endsequence
    sequence s_cx(logic [7:0] t);
        s_run(I_XREG_OP) ##0 ct_q == t;
    endsequence

    property p_acc_coord;
        logic [4:0] s;
        logic [31:0] v;
        (s_run(I_ACCU_COORD), s = ct_q[4:0], v = acc_o) ##1 1'b1 |-> crd_q[s] == v;
    endproperty
    a_acc_coord: assert property (p_acc_coord) else $error("slot not loaded");
    property p_persist_def;
        $rose(rst_b_i) |-> !persist_o [*2];
    endproperty
    a_persist_def: assert property (p_persist_def) else $error("persist set");
    property p_nv_slot0;
        nv_we_o |-> nv_slot_o != 5'h00 && $past(persist_q);
    endproperty
    a_nv_slot0: assert property (p_nv_slot0) else $error("bad nv write");
    property p_reply;
        s_run(I_XREG_OP) ##0 dir_q |=> reply_valid_o && reply_status_o == ST_OK
            ##1 !reply_valid_o;
    endproperty
    a_reply: assert property (p_reply) else $error("reply wrong");
    property p_add;
        s_cx(CX_ADD) |=> acc_o == 32'($past(acc_o) + $past(xreg_o));
    endproperty
    a_add: assert property (p_add) else $error("add wrong");
    property p_xor;
        s_cx(CX_XOR) |=> acc_o == ($past(acc_o) ^ $past(xreg_o)) && $stable(xreg_o);
    endproperty
    a_xor: assert property (p_xor) else $error("xor wrong");
    property p_load;
        s_cx(CX_LOAD) |=> xreg_o == $past(acc_o) && $stable(acc_o);
    endproperty
    a_load: assert property (p_load) else $error("load wrong");
    property p_swap;
        s_cx(CX_SWAP) |=> xreg_o == $past(acc_o) && acc_o == $past(xreg_o);
    endproperty
    a_swap: assert property (p_swap) else $error("swap wrong");
    property p_acc_axis;
        s_run(I_ACCU_AXIS) |=> ap_we_o && ap_data_o == $past(acc_o) ##1 !ap_we_o;
    endproperty
    a_acc_axis: assert property (p_acc_axis) else $error("axis write wrong");
    property p_global_bank;
        gp_we_o |-> gp_bank_o == BANK_0 || gp_bank_o == BANK_2 || gp_bank_o == BANK_3;
    endproperty
    a_global_bank: assert property (p_global_bank) else $error("bad bank");
    property p_csum;
        fend && sum_q != byte_data_i |-> ##1 !ex ##1 (!ap_we_o && !gp_we_o && !nv_we_o);
    endproperty
    a_csum: assert property (p_csum) else $error("bad frame executed");
endmodule : atc_immediate_cmd_a

/* test/atc_host_model.sv */
`timescale 1ns/1ns
module atc_host_model (
    input wire logic ref_clk_i,
    input wire logic byte_ready_i,
    input wire logic prog_ready_i,
    output logic byte_valid_o,
    output logic [7:0] byte_data_o,
    output logic prog_valid_o,
    output logic [7:0] prog_instr_o,
    output logic [7:0] prog_type_o,
    output logic [7:0] prog_bank_o
);
    import atc_pkg::*;

    initial begin
        byte_valid_o = 1'b0;
        byte_data_o = 8'hA5;
        prog_valid_o = 1'b0;
        {prog_instr_o, prog_type_o, prog_bank_o} = 24'h5A5A5A;
    end

    // Holds the offer until an edge that samples the matching ready high.
    task automatic wait_take(input bit is_prog);
        logic rdy;
        do begin
            @(negedge ref_clk_i);
            rdy = is_prog ? prog_ready_i : byte_ready_i;
            @(posedge ref_clk_i);
        end while (!rdy);
        #1;
    endtask : wait_take

    // A nonzero gap idles the line between bytes, as a slow sender would.
    task automatic send_frame(input logic [7:0] ins, ty, bk, input logic [31:0] val,
                              input logic bad, input int axis_param_read_cmd);
        logic [7:0] fr [0:8];
        fr = '{MOD_ADDR, ins, ty, bk, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
        for (int i = 0; i < 8; i++) begin
            fr[8] = fr[8] + fr[i];
        end
        fr[8] = fr[8] ^ {7'h00, bad};
        for (int i = 0; i < 9; i++) begin
            byte_valid_o = 1'b1;
            byte_data_o = fr[i];
            wait_take(1'b0);
            if (axis_param_read_cmd > 0 && i < 8) begin
                byte_valid_o = 1'b0;
                byte_data_o = ~byte_data_o;
                repeat (axis_param_read_cmd) @(posedge ref_clk_i);
                #1;
            end
        end
        byte_valid_o = 1'b0;
        byte_data_o = ~byte_data_o;
    endtask : send_frame

    task automatic prog_cmd(input logic [7:0] ins, ty, bk);
        prog_valid_o = 1'b1;
        {prog_instr_o, prog_type_o, prog_bank_o} = {ins, ty, bk};
        wait_take(1'b1);
        prog_valid_o = 1'b0;
        {prog_instr_o, prog_type_o, prog_bank_o} = ~{ins, ty, bk};
    endtask : prog_cmd
endmodule : atc_host_model

/* test/accumulator_transfer_immediate_cmd_a_tb.sv */
`timescale 1ns/1ns
module accumulator_transfer_immediate_cmd_a_tb;
    import atc_pkg::*;
    logic ref_clk_i, rst_b_i, byte_valid_i, byte_ready_o, prog_valid_i, prog_ready_o;
    logic prog_done_o, acc_load_i, nv_restore_i, reply_valid_o, ap_we_o, gp_we_o;
    logic nv_we_o, persist_o;
    logic [7:0] byte_data_i, prog_instr_i, prog_type_i, prog_bank_i, reply_status_o;
    logic [7:0] ap_num_o, ap_motor_o, gp_num_o, gp_bank_o;
    logic [4:0] nv_slot_i, coord_sel_i, nv_slot_o;
    logic [31:0] acc_load_val_i, nv_data_i, coord_o, reply_value_o, ap_data_o;
    logic [31:0] gp_data_o, nv_data_o, acc_o, xreg_o;
    int n_fail = 0;
    int checked = 0;

    atc_immediate_cmd_a dut (.ref_clk_i, .rst_b_i, .byte_valid_i, .byte_data_i, .byte_ready_o,
        .prog_valid_i, .prog_instr_i, .prog_type_i, .prog_bank_i, .prog_ready_o,
        .prog_done_o, .acc_load_i, .acc_load_val_i, .nv_restore_i, .nv_slot_i, .nv_data_i,
        .coord_sel_i, .coord_o, .reply_valid_o, .reply_status_o, .reply_value_o, .ap_we_o,
        .ap_num_o, .ap_motor_o, .ap_data_o, .gp_we_o, .gp_num_o, .gp_bank_o, .gp_data_o,
        .nv_we_o, .nv_slot_o, .nv_data_o, .acc_o, .xreg_o, .persist_o);

    atc_host_model host (.ref_clk_i, .byte_ready_i(byte_ready_o), .prog_ready_i(prog_ready_o),
        .byte_valid_o(byte_valid_i), .byte_data_o(byte_data_i), .prog_valid_o(prog_valid_i),
        .prog_instr_o(prog_instr_i), .prog_type_o(prog_type_i), .prog_bank_o(prog_bank_i));

    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic step();
        @(posedge ref_clk_i);
        #1;
    endtask : step

    task automatic load_acc(input logic [31:0] v);
        acc_load_i = 1'b1;
        acc_load_val_i = v;
        step();
        acc_load_i = 1'b0;
    endtask : load_acc

    // Returns in the cycle where the reply pulse and the command's effects stand.
    task automatic do_frame(input logic [7:0] ins, ty, bk, input logic bad, input int axis_param_read_cmd);
        host.send_frame(ins, ty, bk, 32'h5A5A_5A5A, bad, axis_param_read_cmd);
        step();
        chk("reply_valid_o", 32'h1, {31'h0, reply_valid_o});
        chk("reply_value_o", 32'h0, reply_value_o);
    endtask : do_frame

    task automatic do_prog(input logic [7:0] ins, ty, bk);
        host.prog_cmd(ins, ty, bk);
        step();
        chk("prog_done_o", 32'h1, {31'h0, prog_done_o});
    endtask : do_prog

    task automatic read_coord(input logic [4:0] sel, input logic [31:0] exp);
        coord_sel_i = sel;
        step();
        step();
        chk("coord_o", exp, coord_o);
    endtask : read_coord

    function automatic logic [63:0] arith_ref(input int t, input logic [31:0] a, x);
        case (t)
            0: return {a + x, x};
            1: return {a - x, x};
            2: return {a * x, x};
            3: return {32'($signed(a) / $signed(x)), x};
            4: return {32'($signed(a) % $signed(x)), x};
            5: return {a & x, x};
            6: return {a | x, x};
            7: return {a ^ x, x};
            8: return {a, ~x};
            9: return {a, a};
            default: return {x, a};
        endcase
    endfunction : arith_ref

    task automatic test_xreg_ops();
        logic [63:0] e;
        for (int t = 0; t <= 10; t++) begin
            load_acc(32'h0000_0007);
            do_prog(I_XREG_OP, CX_LOAD, 8'h00);
            load_acc(32'hFFFF_FF9C);
            if (t == 10) do_frame(I_XREG_OP, 8'(t), 8'h00, 1'b0, 1);
            else do_prog(I_XREG_OP, 8'(t), 8'h00);
            e = arith_ref(t, 32'hFFFF_FF9C, 32'h0000_0007);
            chk("acc_o", e[63:32], acc_o);
            chk("xreg_o", e[31:0], xreg_o);
            chk("reply_status_o", {24'h0, ST_OK}, {24'h0, reply_status_o});
        end
        $display("Test X register operations finished");
    endtask : test_xreg_ops

    task automatic test_coord();
        chk("byte_ready_o", 32'h1, {31'h0, byte_ready_o});
        chk("prog_ready_o", 32'h1, {31'h0, prog_ready_o});
        chk("persist_o", 32'h0, {31'h0, persist_o});
        load_acc(32'h0000_1234);
        do_frame(I_ACCU_COORD, 8'h01, MOTOR_0, 1'b0, 0);
        chk("nv_we_o", 32'h0, {31'h0, nv_we_o});
        read_coord(5'h01, 32'h0000_1234);
        load_acc(32'h0000_0001);
        do_frame(I_ACCU_GLOBAL, GP_PERSIST, BANK_0, 1'b0, 0);
        step();
        chk("persist_o", 32'h1, {31'h0, persist_o});
        load_acc(32'hABCD_0000);
        do_frame(I_ACCU_COORD, 8'h00, MOTOR_0, 1'b0, 0);
        chk("nv_we_o", 32'h0, {31'h0, nv_we_o});
        read_coord(5'h00, 32'hABCD_0000);
        load_acc(32'h0000_0055);
        do_frame(I_ACCU_COORD, COORD_MAX, MOTOR_0, 1'b0, 1);
        chk("nv_we_o", 32'h1, {31'h0, nv_we_o});
        chk("nv_slot_o", 32'h14, {27'h0, nv_slot_o});
        chk("nv_data_o", 32'h0000_0055, nv_data_o);
        nv_restore_i = 1'b1;
        nv_slot_i = 5'h03;
        nv_data_i = 32'h0000_0777;
        step();
        nv_restore_i = 1'b0;
        read_coord(5'h03, 32'h0000_0777);
        $display("Test coordinates finished");
    endtask : test_coord

    task automatic test_params();
        load_acc(32'h0000_0C80);
        do_frame(I_ACCU_AXIS, 8'h04, MOTOR_0, 1'b0, 0);
        chk("ap_we_o", 32'h1, {31'h0, ap_we_o});
        chk("ap_num_o", 32'h4, {24'h0, ap_num_o});
        chk("ap_motor_o", {24'h0, MOTOR_0}, {24'h0, ap_motor_o});
        chk("ap_data_o", 32'h0000_0C80, ap_data_o);
        do_prog(I_ACCU_GLOBAL, 8'h2A, BANK_2);
        chk("gp_we_o", 32'h1, {31'h0, gp_we_o});
        chk("gp_num_o", 32'h2A, {24'h0, gp_num_o});
        chk("gp_data_o", 32'h0000_0C80, gp_data_o);
        do_prog(I_ACCU_GLOBAL, 8'h2A, BANK_3);
        chk("gp_bank_o", 32'h3, {24'h0, gp_bank_o});
        do_frame(I_ACCU_GLOBAL, 8'h2A, 8'h01, 1'b0, 0);
        chk("gp_we_o", 32'h0, {31'h0, gp_we_o});
        chk("reply_status_o", {24'h0, ST_BAD_VAL}, {24'h0, reply_status_o});
        do_frame(I_ACCU_AXIS, 8'h04, MOTOR_0, 1'b1, 0);
        chk("ap_we_o", 32'h0, {31'h0, ap_we_o});
        chk("reply_status_o", {24'h0, ST_BAD_CSUM}, {24'h0, reply_status_o});
        $display("Test parameters finished");
    endtask : test_params

    // Refused commands must report their status and leave all state untouched.
    task automatic test_refused();
        do_frame(8'h24, 8'h00, 8'h00, 1'b0, 0);
        chk("byte_ready_o", 32'h0, {31'h0, byte_ready_o});
        chk("reply_status_o", {24'h0, ST_BAD_CMD}, {24'h0, reply_status_o});
        load_acc(32'h0000_0066);
        do_frame(I_ACCU_COORD, 8'h15, MOTOR_0, 1'b0, 0);
        chk("reply_status_o", {24'h0, ST_BAD_TYPE}, {24'h0, reply_status_o});
        chk("nv_we_o", 32'h0, {31'h0, nv_we_o});
        do_prog(I_XREG_OP, 8'h0B, 8'h00);
        chk("reply_status_o", {24'h0, ST_BAD_TYPE}, {24'h0, reply_status_o});
        load_acc(32'h0000_0000);
        do_prog(I_XREG_OP, CX_LOAD, 8'h00);
        load_acc(32'h0000_0005);
        do_prog(I_XREG_OP, CX_DIV, 8'h00);
        chk("reply_status_o", {24'h0, ST_BAD_VAL}, {24'h0, reply_status_o});
        chk("acc_o", 32'h0000_0005, acc_o);
        $display("Test refused commands finished");
    endtask : test_refused

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        n_fail++;
        $display("Watchdog expired");
        tally_and_finish();
    end

    initial begin
        rst_b_i = 1'b0;
        {acc_load_i, nv_restore_i, nv_slot_i, coord_sel_i} = 12'h000;
        {acc_load_val_i, nv_data_i} = 64'h0;
        repeat (5) @(posedge ref_clk_i);
        #1;
        rst_b_i = 1'b1;
        step();
        step();
        test_coord();
        test_xreg_ops();
        test_params();
        test_refused();
        tally_and_finish();
    end
endmodule : accumulator_transfer_immediate_cmd_a_tb
